// *** core/wit_pkg.sv ***
// Shared constants, types and helpers for the watchdog/interval timer
package wit_pkg;

  // Bus addresses: one keyed write address, two byte read addresses
  localparam logic [15:0] WIT_WR_ADDR = 16'hffa8;
  localparam logic [15:0] WIT_CSR_ADDR = 16'hffa8;
  localparam logic [15:0] WIT_CNT_ADDR = 16'hffa9;

  // Keys carried in the upper byte of a word write
  localparam logic [7:0] WIT_KEY_CNT = 8'h5a;
  localparam logic [7:0] WIT_KEY_CSR = 8'ha5;

  // Control-status field positions
  localparam int WIT_OVF_BIT = 7;
  localparam int WIT_MODE_BIT = 6;
  localparam int WIT_TME_BIT = 5;
  localparam int WIT_PSS_BIT = 4;
  localparam int WIT_ACT_BIT = 3;
  localparam int WIT_CKS_MSB = 2;
  localparam int WIT_CKS_LSB = 0;

  // Reset values
  localparam logic [7:0] WIT_CSR_RST = 8'h00;
  localparam logic [7:0] WIT_CNT_RST = 8'h00;
  localparam logic [7:0] WIT_CNT_MAX = 8'hff;

  // Internal reset length in system clocks
  localparam logic [9:0] WIT_RST_CYCLES = 10'h206;

  // Prescaler width covers the deepest main-clock tap (clk/131072)
  localparam int WIT_PRE_W = 17;

  typedef enum logic {
    WIT_RUN = 1'b0,
    WIT_HOLD = 1'b1
  } wit_rsm_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } wit_bus_req_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } wit_sync_s;

  typedef struct packed {
    logic [WIT_PRE_W-1:0] cnt;
  } wit_pre_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic ovf;
    logic mode;
    logic timer_enable;
    logic prescaler_source_select;
    logic act;
    logic [2:0] cks;
    logic ovf_seen;
    logic tap_prev;
    wit_rsm_e rsm;
    logic [9:0] rst_cnt;
    logic [7:0] rdata;
    logic irq;
    logic nmi;
    logic wrst;
    logic src;
  } wit_state_s;

  // Prescaler bit whose falling edge gives the selected tick
  function automatic logic [4:0] wit_tap(input logic prescaler_source_select, input logic [2:0] cks);
    logic [4:0] idx;
    idx = 5'h00;
    if (prescaler_source_select) begin
      idx = {2'b00, cks};
    end else begin
      case (cks)
        3'h0: idx = 5'h00;
        3'h1: idx = 5'h05;
        3'h2: idx = 5'h06;
        3'h3: idx = 5'h08;
        3'h4: idx = 5'h0a;
        3'h5: idx = 5'h0c;
        3'h6: idx = 5'h0e;
        default: idx = 5'h10;
      endcase
    end
    return idx;
  endfunction : wit_tap

endpackage : wit_pkg

// *** core/wit_sync.sv ***
// Three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module wit_sync #(
  parameter logic IDLE = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Pin and filtered result
  input wire logic pin,
  output wit_pkg::wit_sync_s st
);
  import wit_pkg::*;

  wit_sync_s q, n;

  always_comb begin
    n = q;
    n.s1 = pin;
    n.s2 = q.s1;
    n.s3 = q.s2;
    // Only accept a level once the last two stages agree
    if (q.s2 == q.s3) begin
      n.lvl = q.s3;
    end
    n.rise = n.lvl & ~q.lvl;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{s1: IDLE, s2: IDLE, s3: IDLE, lvl: IDLE, rise: 1'b0};
    end else if (ce) begin
      q <= n;
    end
  end

  assign st = q;

endmodule : wit_sync

// *** core/wit_prescaler.sv ***
// Free-running prescaler counter advanced by a count enable
`timescale 1ns/1ps
module wit_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Advance strobe and count
  input wire logic inc,
  output wit_pkg::wit_pre_s st
);
  import wit_pkg::*;

  wit_pre_s q, n;

  always_comb begin
    n = q;
    if (inc) begin
      n.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  assign st = q;

endmodule : wit_prescaler

// *** core/wit_top.sv ***
// Watchdog / interval timer with keyed word-write register access
`timescale 1ns/1ps

// Behaviour
// - Main clock taps divide by 2..131072
// - Sub clock taps divide by 2..256
// - Overflow flag cleared by writing zero after reading it set
// - Watchdog mode when mode and enable set
// - Watchdog overflow gives reset or NMI
// - Reset action holds reset 518 cycles
// - NMI action raises non-maskable request
// - Shared reset vector; pin reset wins
// - Interval overflow raises interrupt with flag
// - Interrupt follows flag; handler clears flag
// - Only word writes change registers
// - Upper byte key selects counter or control
// - Byte reads at ffa8 and ffa9
// - Counter write beats a simultaneous tick
// - Enable starts; disable stops and zeroes
// - Flag set on ff to 00 rollover
// - Flag cleared by write, disable, reset
// - Source bit picks main or sub prescaler
module wit_top (
  // Clock, reset, freeze
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // CPU bus
  input wire wit_pkg::wit_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  // Pins
  input wire logic sub_clk_pin,
  input wire logic ext_rst_n_pin,
  // Requests and status
  output logic interval_overflow_interrupt,
  output logic wdt_nmi_req,
  output logic wdt_reset_req,
  output logic reset_source_flag
);
  import wit_pkg::*;

  wit_state_s q, n;
  wit_sync_s sub_s, ext_s;
  wit_pre_s main_pre, sub_pre;

  logic [4:0] tap;
  logic tap_bit;
  logic tick;
  logic wr_word;
  logic wr_cnt;
  logic wr_csr;
  logic ovfl;
  logic wdog;
  logic [7:0] csr_val;

  wit_sync #(
    .IDLE(1'b0)
  ) u_sub_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .pin(sub_clk_pin),
    .st(sub_s)
  );

  wit_sync #(
    .IDLE(1'b1)
  ) u_ext_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .pin(ext_rst_n_pin),
    .st(ext_s)
  );

  // Both prescalers run free so a tap change never restarts them
  wit_prescaler u_main_pre (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .inc(1'b1),
    .st(main_pre)
  );

  wit_prescaler u_sub_pre (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .inc(sub_s.rise),
    .st(sub_pre)
  );

  always_comb begin
    tap = wit_tap(q.prescaler_source_select, q.cks);
    tap_bit = q.prescaler_source_select ? sub_pre.cnt[tap] : main_pre.cnt[tap];
    // Falling edge of a tap bit marks one divided period
    tick = q.timer_enable & q.tap_prev & ~tap_bit;
    wr_word = bus_req.wr & bus_req.word & (bus_req.addr == WIT_WR_ADDR);
    wr_cnt = wr_word & (bus_req.wdata[15:8] == WIT_KEY_CNT);
    wr_csr = wr_word & (bus_req.wdata[15:8] == WIT_KEY_CSR);
    ovfl = tick & ~wr_cnt & (q.cnt == WIT_CNT_MAX);
    wdog = q.mode & q.timer_enable;
    csr_val = {q.ovf, q.mode, q.timer_enable, q.prescaler_source_select, q.act, q.cks};
  end

  always_comb begin
    n = q;
    // Edge detector idles low while stopped, so a tap chosen while stopped gives no false tick
    n.tap_prev = q.timer_enable & tap_bit;
    n.nmi = 1'b0;

    // Counter: written value beats a coincident tick
    if (wr_cnt) begin
      n.cnt = bus_req.wdata[7:0];
    end else if (tick) begin
      n.cnt = q.cnt + 1'b1;
    end

    // Control-status write; flag bit accepts only a zero
    if (wr_csr) begin
      n.mode = bus_req.wdata[WIT_MODE_BIT];
      n.timer_enable = bus_req.wdata[WIT_TME_BIT];
      n.prescaler_source_select = bus_req.wdata[WIT_PSS_BIT];
      n.act = bus_req.wdata[WIT_ACT_BIT];
      n.cks = bus_req.wdata[WIT_CKS_MSB:WIT_CKS_LSB];
      if (!bus_req.wdata[WIT_OVF_BIT] && q.ovf_seen) begin
        n.ovf = 1'b0;
      end
      if (!bus_req.wdata[WIT_TME_BIT]) begin
        n.ovf = 1'b0;
      end
    end

    // Disabled timer holds zero
    if (!n.timer_enable) begin
      n.cnt = WIT_CNT_RST;
    end

    // Internal reset clears the flag while it is held
    if (q.rsm == WIT_HOLD) begin
      n.ovf = 1'b0;
    end

    // Hardware set wins over any clear in the same cycle
    if (ovfl) begin
      n.ovf = 1'b1;
    end

    // A read of a set flag arms the zero-write clear
    if (!n.ovf) begin
      n.ovf_seen = 1'b0;
    end else if (bus_req.rd && bus_req.addr == WIT_CSR_ADDR && q.ovf) begin
      n.ovf_seen = 1'b1;
    end

    // Reads return byte registers; others read zero
    if (bus_req.rd) begin
      if (bus_req.addr == WIT_CSR_ADDR) begin
        n.rdata = csr_val;
      end else if (bus_req.addr == WIT_CNT_ADDR) begin
        n.rdata = q.cnt;
      end else begin
        n.rdata = 8'h00;
      end
    end

    // Watchdog action sequencer
    case (q.rsm)
      WIT_RUN: begin
        if (ovfl && wdog) begin
          if (q.act) begin
            n.rsm = WIT_HOLD;
            n.rst_cnt = 10'h000;
            n.wrst = 1'b1;
          end else begin
            n.nmi = 1'b1;
          end
        end
      end
      WIT_HOLD: begin
        n.rst_cnt = q.rst_cnt + 10'h001;
        if (q.rst_cnt == WIT_RST_CYCLES - 10'h001) begin
          n.rsm = WIT_RUN;
          n.wrst = 1'b0;
        end
      end
      default: begin
        n.rsm = WIT_RUN;
        n.wrst = 1'b0;
      end
    endcase

    // Reset source: pin reset takes priority when both coincide
    if (!ext_s.lvl) begin
      n.src = 1'b1;
    end else if (ovfl && wdog && q.act && q.rsm == WIT_RUN) begin
      n.src = 1'b0;
    end

    // Interval request follows the flag outside watchdog mode
    n.irq = n.ovf & ~n.mode;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{cnt: WIT_CNT_RST, ovf: WIT_CSR_RST[WIT_OVF_BIT],
             mode: WIT_CSR_RST[WIT_MODE_BIT], timer_enable: WIT_CSR_RST[WIT_TME_BIT],
             prescaler_source_select: WIT_CSR_RST[WIT_PSS_BIT], act: WIT_CSR_RST[WIT_ACT_BIT],
             cks: WIT_CSR_RST[WIT_CKS_MSB:WIT_CKS_LSB], ovf_seen: 1'b0,
             tap_prev: 1'b0, rsm: WIT_RUN, rst_cnt: 10'h000, rdata: 8'h00,
             irq: 1'b0, nmi: 1'b0, wrst: 1'b0, src: 1'b0};
    end else if (ce) begin
      q <= n;
    end
  end

  assign bus_rdata = q.rdata;
  assign interval_overflow_interrupt = q.irq;
  assign wdt_nmi_req = q.nmi;
  assign wdt_reset_req = q.wrst;
  assign reset_source_flag = q.src;

  // Helper: cycles elapsed so far in the current internal reset pulse
  logic [10:0] rst_len_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_len_q <= 11'h000;
    end else if (ce) begin
      rst_len_q <= q.wrst ? rst_len_q + 11'h001 : 11'h000;
    end
  end

  AST_BYTE_WR: assert property (
    @(posedge clk) disable iff (!rstn)
    (ce && bus_req.wr && !bus_req.word && !tick && q.rsm == WIT_RUN && q.timer_enable)
      |=> (csr_val[6:0] == $past(csr_val[6:0]) && q.cnt == $past(q.cnt)))
    else $error("byte write altered a register");

  AST_KEY_CNT: assert property (
    @(posedge clk) disable iff (!rstn)
    (ce && wr_cnt && q.timer_enable && !wr_csr) |=> (q.cnt == $past(bus_req.wdata[7:0])))
    else $error("keyed counter write not loaded");

  AST_KEY_CSR: assert property (
    @(posedge clk) disable iff (!rstn)
    (ce && wr_csr) |=> (q.cks == $past(bus_req.wdata[2:0]) && q.timer_enable == $past(bus_req.wdata[5])))
    else $error("keyed control write not loaded");

  AST_RST_LEN: assert property (
    @(posedge clk) disable iff (!rstn)
    (ce && q.wrst && !n.wrst) |-> (rst_len_q == 11'd517))
    else $error("internal reset length is not 518 cycles");

  AST_NMI_SEL: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(wdt_nmi_req) |-> ($past(q.mode) && !$past(q.act) && $past(q.timer_enable)))
    else $error("NMI without watchdog NMI selection");

  AST_IRQ_OVF: assert property (
    @(posedge clk) disable iff (!rstn)
    ($rose(q.ovf) && !q.mode) |-> interval_overflow_interrupt)
    else $error("interval request not raised with flag");

  AST_OVF_W1: assert property (
    @(posedge clk) disable iff (!rstn)
    (ce && !q.ovf && !ovfl) |=> !q.ovf)
    else $error("flag set without overflow");

  AST_TME_OFF: assert property (
    @(posedge clk) disable iff (!rstn)
    !q.timer_enable |-> (q.cnt == WIT_CNT_RST))
    else $error("stopped counter not zero");

  AST_SRC_PIN: assert property (
    @(posedge clk) disable iff (!rstn)
    (ce && !ext_s.lvl) |=> reset_source_flag)
    else $error("pin reset did not set source flag");

  AST_RD_CNT: assert property (
    @(posedge clk) disable iff (!rstn)
    (ce && bus_req.rd && bus_req.addr == WIT_CNT_ADDR) |=> (bus_rdata == $past(q.cnt)))
    else $error("counter read mismatch");

  AST_T2_WIN: assert property (
    @(posedge clk) disable iff (!rstn)
    (ce && wr_cnt && tick && !wr_csr) |=> (q.cnt == $past(bus_req.wdata[7:0])))
    else $error("tick beat a counter write");

endmodule : wit_top

// *** verif/wit_cpu_model.sv ***
// CPU-side bus master model: keyed word writes and byte reads
`timescale 1ns/1ps
module wit_cpu_model (
  // Clock
  input wire logic clk,
  // Peripheral bus
  output wit_pkg::wit_bus_req_s bus_req,
  input wire logic [7:0] bus_rdata
);
  import wit_pkg::*;
  initial begin
    bus_req = '0;
  end
  // Released address and data show inverted junk, never the last value
  task automatic drop();
    @(negedge clk);
    bus_req.rd = 1'b0;
    bus_req.wr = 1'b0;
    bus_req.addr = ~bus_req.addr;
    bus_req.wdata = ~bus_req.wdata;
  endtask : drop
  task automatic wr(input logic [7:0] key, input logic [7:0] data, input logic word);
    @(negedge clk);
    bus_req.wr = 1'b1;
    bus_req.word = word;
    bus_req.addr = WIT_WR_ADDR;
    bus_req.wdata = {key, data};
    drop();
  endtask : wr
  task automatic rd(input logic [15:0] addr, output logic [7:0] data);
    @(negedge clk);
    bus_req.rd = 1'b1;
    bus_req.word = 1'b0;
    bus_req.addr = addr;
    drop();
    @(negedge clk);
    data = bus_rdata;
  endtask : rd
  // Flag only counts as seen after two reads of one
  task automatic poll(output logic seen);
    logic [7:0] a;
    logic [7:0] b;
    rd(WIT_CSR_ADDR, a);
    rd(WIT_CSR_ADDR, b);
    seen = a[WIT_OVF_BIT] & b[WIT_OVF_BIT];
  endtask : poll
endmodule : wit_cpu_model

// *** verif/tb_wit_top.sv ***
// Self-checking bench for the watchdog / interval timer
`timescale 1ns/1ps
module tb_wit_top;
  import wit_pkg::*;
  logic clk;
  logic rstn;
  logic ce;
  logic sub_clk;
  logic ext_rst_n;
  wit_bus_req_s bus_req;
  logic [7:0] bus_rdata;
  logic irq;
  logic nmi;
  logic wrst;
  logic src;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] d;
  logic [7:0] v;
  logic seen;
  int t1;
  int t2;

  wit_top i_wit_top (.clk(clk), .rstn(rstn), .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .sub_clk_pin(sub_clk), .ext_rst_n_pin(ext_rst_n), .interval_overflow_interrupt(irq),
    .wdt_nmi_req(nmi), .wdt_reset_req(wrst), .reset_source_flag(src));
  wit_cpu_model i_wit_cpu_model (.clk(clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Sub clock of 12 system clocks, offset so edges never coincide
  initial begin
    sub_clk = 1'b0;
    #3;
    forever #48 sub_clk = ~sub_clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic done(input string n);
    $display("test %s done", n);
  endtask : done
  task automatic wcsr(input logic [7:0] x);
    i_wit_cpu_model.wr(WIT_KEY_CSR, x, 1'b1);
  endtask : wcsr
  task automatic wcnt(input logic [7:0] x);
    i_wit_cpu_model.wr(WIT_KEY_CNT, x, 1'b1);
  endtask : wcnt
  task automatic rd(input logic [15:0] a, output logic [7:0] x);
    i_wit_cpu_model.rd(a, x);
  endtask : rd
  // Bounded wait for nmi (0), reset (1) or irq (2)
  task automatic wait_hi(input int sel, input int bound, output int t);
    logic s;
    t = -1;
    for (int i = 0; i < bound; i++) begin
      @(negedge clk);
      s = (sel == 0) ? nmi : (sel == 1) ? wrst : irq;
      if (s === 1'b1) begin
        t = cyc;
        break;
      end
    end
    check("request seen", 1, t >= 0);
  endtask : wait_hi
  function automatic int exp_div(input logic prescaler_source_select, input logic [2:0] cks);
    int main_div [8] = '{2, 64, 128, 512, 2048, 8192, 32768, 131072};
    return prescaler_source_select ? (2 << cks) * 12 : main_div[cks];
  endfunction : exp_div
  // Cycles between two overflows with the counter reloaded to ff
  task automatic period(input logic prescaler_source_select, input logic [2:0] cks);
    int ta;
    int tb;
    wcsr(8'h00);
    wcsr({3'b011, prescaler_source_select, 1'b0, cks});
    wcnt(8'hff);
    wait_hi(0, 2 * exp_div(prescaler_source_select, cks) + 60, ta);
    wcnt(8'hff);
    wait_hi(0, exp_div(prescaler_source_select, cks) + 60, tb);
    check("tick period", exp_div(prescaler_source_select, cks), tb - ta);
  endtask : period

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    ext_rst_n = 1'b1;
    v = 8'($urandom(32'h4cb7));
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    rd(WIT_CSR_ADDR, d);
    check("csr reset", WIT_CSR_RST, d);
    rd(WIT_CNT_ADDR, d);
    check("cnt reset", WIT_CNT_RST, d);
    wcsr(8'h27);
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      wcnt(v);
      rd(WIT_CNT_ADDR, d);
      check("cnt write", v, d);
      i_wit_cpu_model.wr(WIT_KEY_CNT, ~v, 1'b0);
      i_wit_cpu_model.wr(8'h33, ~v, 1'b1);
      rd(WIT_CNT_ADDR, d);
      check("cnt guarded", v, d);
    end
    rd(WIT_CSR_ADDR, d);
    check("csr write", 8'h27, d);
    // Frozen block must ignore a keyed write
    ce = 1'b0;
    wcnt(~v);
    ce = 1'b1;
    rd(WIT_CNT_ADDR, d);
    check("cnt frozen", v, d);
    rd(16'hffaa, d);
    check("unmapped read", 8'h00, d);
    done("registers");
    wcsr(8'h00);
    // Stopped counter holds zero, so preload only once running
    wcsr(8'h20);
    wcnt(8'hfd);
    wait_hi(2, 40, t1);
    i_wit_cpu_model.poll(seen);
    check("flag polled", 1, seen);
    wcsr(8'ha0);
    rd(WIT_CSR_ADDR, d);
    check("flag kept", 1, d[WIT_OVF_BIT]);
    check("irq follows flag", 1, irq);
    wcsr(8'h20);
    @(negedge clk);
    check("irq cleared", 0, irq);
    wcsr(8'h00);
    rd(WIT_CNT_ADDR, d);
    check("cnt zeroed", 8'h00, d);
    done("interval");
    for (int c = 1; c < 6; c++) begin
      period(1'b0, 3'(c));
    end
    for (int c = 0; c < 8; c++) begin
      period(1'b1, 3'(c));
    end
    done("tick rates");
    ext_rst_n = 1'b0;
    repeat (6) @(negedge clk);
    ext_rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check("pin reset source", 1, src);
    wcsr(8'h00);
    wcsr(8'h69);
    wcnt(8'hfd);
    wait_hi(1, 300, t1);
    t2 = 1;
    while (t2 < 1000) begin
      @(negedge clk);
      if (wrst !== 1'b1) begin
        break;
      end
      t2++;
    end
    check("reset length", 518, t2);
    check("wdt reset source", 0, src);
    rd(WIT_CSR_ADDR, d);
    check("flag auto clear", 0, d[WIT_OVF_BIT]);
    wcsr(8'h00);
    done("watchdog reset");
    stop_test();
  end
endmodule : tb_wit_top
